/* rtl/emd_pkg.sv */
/*
 * Constants, types, pattern table and shared decode functions for the
 * encoding match decoder.
 * Assumes 16-bit instruction words and a small fixed pattern table.
 */
package emd_pkg;

    // ------------------------------------------------------------
    // Widths and sizes
    // ------------------------------------------------------------
    localparam int INSN_W = 16;
    localparam int NUM_PAT = 4;
    localparam int PID_W = 2;
    localparam int FLD_W = 8;
    localparam int CNT_W = 3;

    // ------------------------------------------------------------
    // Fallback space and condition codes
    // ------------------------------------------------------------
    localparam logic [INSN_W-1:0] HINT_MASK = 16'hff0f;
    localparam logic [INSN_W-1:0] HINT_VAL  = 16'hbf00;
    localparam logic [3:0]        COND_AL   = 4'he;
    localparam logic [3:0]        COND_NV   = 4'hf;
    localparam logic [INSN_W-1:0] INSN_RST  = 16'h0000;
    localparam logic [FLD_W-1:0]  FLD_RST   = 8'h00;
    localparam logic [PID_W-1:0]  PID_RST   = 2'h0;
    localparam logic [CNT_W-1:0]  CNT_RST   = 3'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        EMD_EXEC,
        EMD_NOP,
        EMD_UNDEF,
        EMD_UNPRED
    } emd_outcome_t;

    typedef enum logic [2:0] {
        EMD_WHY_NONE,
        EMD_WHY_NO_MATCH,
        EMD_WHY_HINT,
        EMD_WHY_COND_FAIL,
        EMD_WHY_AMBIGUOUS,
        EMD_WHY_SPECIAL,
        EMD_WHY_SHOULD_BE
    } emd_reason_t;

    typedef struct packed {
        logic [INSN_W-1:0] fix_mask;
        logic [INSN_W-1:0] fix_val;
        logic [INSN_W-1:0] sb_mask;
        logic [INSN_W-1:0] sb_val;
        logic              has_cond;
        logic              yld_en;
        logic [INSN_W-1:0] yld_mask;
        logic [INSN_W-1:0] yld_val;
        logic              cons_en;
        logic [3:0]        cons_a_lsb;
        logic [3:0]        cons_b_lsb;
        logic [3:0]        cons_w;
        logic [3:0]        fa_lsb;
        logic [3:0]        fa_w;
        logic [3:0]        fb_lsb;
        logic [3:0]        fb_w;
    } emd_pat_t;

    // ------------------------------------------------------------
    // Pattern table, a tie between survivors is unpredictable
    // ------------------------------------------------------------
    localparam emd_pat_t PAT_TABLE [NUM_PAT] = '{
        '{16'hf800, 16'h2000, 16'h0000, 16'h0000, 1'b1, 1'b0, 16'h0000, 16'h0000,
          1'b0, 4'h0, 4'h0, 4'h0, 4'h8, 4'h3, 4'h0, 4'h8},
        '{16'hf800, 16'h0000, 16'h0000, 16'h0000, 1'b1, 1'b1, 16'h07c0, 16'h0000,
          1'b0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h3, 4'h3, 4'h3},
        '{16'hffc0, 16'h0000, 16'h0000, 16'h0000, 1'b1, 1'b0, 16'h0000, 16'h0000,
          1'b0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h3, 4'h3, 4'h3},
        '{16'hfe00, 16'h4400, 16'h0080, 16'h0000, 1'b1, 1'b0, 16'h0000, 16'h0000,
          1'b1, 4'h0, 4'h3, 4'h3, 4'h0, 4'h3, 4'h3, 4'h3}
    };

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [FLD_W-1:0] extract(
        input logic [INSN_W-1:0] w,
        input logic [3:0]        lsb,
        input logic [3:0]        wid
    );
        logic [INSN_W-1:0] sh;
        sh = (w >> lsb) & ~(16'hffff << wid);
        return sh[FLD_W-1:0];
    endfunction : extract

    // Flags ordered N Z C V from bit 3 down
    function automatic logic cond_pass(
        input logic [3:0] cond,
        input logic [3:0] nzcv
    );
        logic r;
        case (cond[3:1])
            3'h0:    r = nzcv[2];
            3'h1:    r = nzcv[1];
            3'h2:    r = nzcv[3];
            3'h3:    r = nzcv[0];
            3'h4:    r = nzcv[1] & ~nzcv[2];
            3'h5:    r = (nzcv[3] == nzcv[0]);
            3'h6:    r = (nzcv[3] == nzcv[0]) & ~nzcv[2];
            default: r = 1'b1;
        endcase
        if (cond[0] && cond != COND_NV)
        begin
            r = ~r;
        end
        return r;
    endfunction : cond_pass

endpackage : emd_pkg

/* rtl/emd_dec_if.sv */
/*
 * Internal carrier between the decoder top, its matcher and its field
 * extractor. Purely combinational signals, no clock.
 */
`timescale 1ns/100ps
`default_nettype none

interface emd_dec_if;
    logic [emd_pkg::INSN_W-1:0]  insn;
    logic [emd_pkg::NUM_PAT-1:0] match;
    logic [emd_pkg::NUM_PAT-1:0] applies;
    logic [emd_pkg::NUM_PAT-1:0] special;
    logic [emd_pkg::NUM_PAT-1:0] sb_ok;
    logic                        cond_req;
    logic [emd_pkg::PID_W-1:0]   sel;
    logic [emd_pkg::FLD_W-1:0]   field_a;
    logic [emd_pkg::FLD_W-1:0]   field_b;

    modport mat (input insn, output match, output applies, output special,
                 output sb_ok, output cond_req);
    modport fld (input insn, input sel, output field_a, output field_b);
    modport top (output insn, output sel, input match, input applies,
                 input special, input sb_ok, input cond_req,
                 input field_a, input field_b);
endinterface : emd_dec_if

`default_nettype wire

/* rtl/emd_match.sv */
/*
 * Per-pattern matcher: evaluates every pattern in parallel against the
 * instruction word. Assumes the pattern table in the package.
 */
`timescale 1ns/100ps
`default_nettype none

module emd_match (
    emd_dec_if.mat m
);

    // ------------------------------------------------------------
    // One slice per pattern
    // ------------------------------------------------------------
    for (genvar i = 0; i < emd_pkg::NUM_PAT; i++)
    begin : g_pat
        localparam emd_pkg::emd_pat_t P = emd_pkg::PAT_TABLE[i];

        assign m.match[i] = ((m.insn & P.fix_mask) == P.fix_val);
        assign m.sb_ok[i] = ((m.insn & P.sb_mask) == P.sb_val);
        assign m.applies[i] = !(P.yld_en && ((m.insn & P.yld_mask) == P.yld_val));
        // Agreement of same-named fields
        assign m.special[i] = P.cons_en
            && (emd_pkg::extract(m.insn, P.cons_a_lsb, P.cons_w)
                != emd_pkg::extract(m.insn, P.cons_b_lsb, P.cons_w));
    end

    // All matching patterns share the condition flag, so an OR suffices
    always_comb
    begin
        m.cond_req = 1'b0;
        for (int i = 0; i < emd_pkg::NUM_PAT; i++)
        begin
            if (m.match[i] && emd_pkg::PAT_TABLE[i].has_cond)
            begin
                m.cond_req = 1'b1;
            end
        end
    end

endmodule : emd_match

`default_nettype wire

/* rtl/emd_fields.sv */
/*
 * Field extractor: loads the named fields of the selected pattern from
 * the instruction word. Combinational; the top registers the result.
 */
`timescale 1ns/100ps
`default_nettype none

module emd_fields (
    emd_dec_if.fld f
);

    always_comb
    begin
        emd_pkg::emd_pat_t p;
        p = emd_pkg::PAT_TABLE[f.sel];
        f.field_a = emd_pkg::extract(f.insn, p.fa_lsb, p.fa_w);
        f.field_b = emd_pkg::extract(f.insn, p.fb_lsb, p.fb_w);
    end

endmodule : emd_fields

`default_nettype wire

/* rtl/emd_decoder.sv */
/*
 * Encoding match decoder top: captures a fetched instruction, matches it
 * against all patterns, resolves the survivor and classifies the result.
 * Assumes inputs synchronous to core_clk; fixed two-cycle latency, no
 * back-pressure, one instruction per cycle.
 */
`timescale 1ns/100ps
`default_nettype none

// How it works
// - A pattern matches only if all its fixed bits equal the instruction.
// - A fixed-bit mismatch means another instruction, never a flawed form.
// - Preferred-value bits do not affect matching; a mismatch means unpredictable.
// - Preferred bits checked after resolution and special cases; mismatch gives unpredictable.
// - No match falls back to per-set handling, normally undefined.
// - A failing condition check turns the instruction into a no-operation.
// - All matching patterns share the condition check; it is evaluated once.
// - Patterns match in parallel; fields come from instruction bits of the selected pattern only.
// - Same-named fields must agree; disagreement feeds the special case.
// - Of several matches all but one yield; their results are discarded.
// - A special case in the survivor ends decoding with that classification.
// - Unallocated hint encodings execute as no-operations, not undefined.
// - Execution starts with exactly the fields the survivor decoded.
module emd_decoder (
    input  wire logic                          core_clk,
    input  wire logic                          sys_rst,
    input  wire logic                          clk_en,
    input  wire logic                          in_valid,
    input  wire logic                          in_flush,
    input  wire logic [emd_pkg::INSN_W-1:0]    in_insn,
    input  wire logic [3:0]                    in_cond,
    input  wire logic [3:0]                    in_flags,
    output var  logic                          out_valid,
    output var  emd_pkg::emd_outcome_t         out_outcome,
    output var  emd_pkg::emd_reason_t          out_reason,
    output var  logic [emd_pkg::PID_W-1:0]     out_pat_id,
    output var  logic [emd_pkg::FLD_W-1:0]     out_field_a,
    output var  logic [emd_pkg::FLD_W-1:0]     out_field_b,
    output var  logic [emd_pkg::CNT_W-1:0]     out_match_cnt,
    output var  logic                          out_insn_valid,
    output var  logic [emd_pkg::INSN_W-1:0]    out_insn
);

    // ------------------------------------------------------------
    // Capture stage
    // ------------------------------------------------------------
    logic                        s1_valid_q;
    logic [emd_pkg::INSN_W-1:0]  s1_insn_q;
    logic [3:0]                  s1_cond_q;
    logic [3:0]                  s1_flags_q;

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s1_valid_q <= 1'b0;
        end
        else if (clk_en)
        begin
            s1_valid_q <= in_valid && !in_flush;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s1_insn_q <= emd_pkg::INSN_RST;
        end
        else if (clk_en && in_valid)
        begin
            s1_insn_q <= in_insn;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s1_cond_q <= emd_pkg::COND_AL;
        end
        else if (clk_en && in_valid)
        begin
            s1_cond_q <= in_cond;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s1_flags_q <= 4'h0;
        end
        else if (clk_en && in_valid)
        begin
            s1_flags_q <= in_flags;
        end
    end

    // ------------------------------------------------------------
    // Parallel matching and field extraction
    // ------------------------------------------------------------
    emd_dec_if dec ();

    assign dec.insn = s1_insn_q;

    emd_match u_match (
        .m (dec.mat)
    );

    emd_fields u_fields (
        .f (dec.fld)
    );

    // ------------------------------------------------------------
    // Resolution
    // ------------------------------------------------------------
    logic [emd_pkg::NUM_PAT-1:0] cand;
    logic [emd_pkg::CNT_W-1:0]   match_cnt;
    logic [emd_pkg::CNT_W-1:0]   cand_cnt;
    logic [emd_pkg::PID_W-1:0]   sel;
    logic                        any_match;

    assign cand      = dec.match & dec.applies;
    assign any_match = |dec.match;

    always_comb
    begin
        match_cnt = emd_pkg::CNT_RST;
        cand_cnt  = emd_pkg::CNT_RST;
        sel       = emd_pkg::PID_RST;
        for (int i = emd_pkg::NUM_PAT - 1; i >= 0; i--)
        begin
            if (dec.match[i])
            begin
                match_cnt = match_cnt + 3'h1;
            end
            if (cand[i])
            begin
                cand_cnt = cand_cnt + 3'h1;
                sel      = emd_pkg::PID_W'(i);
            end
        end
    end

    assign dec.sel = sel;

    // ------------------------------------------------------------
    // Classification, in the order the execution model walks
    // ------------------------------------------------------------
    emd_pkg::emd_outcome_t outcome_d;
    emd_pkg::emd_reason_t  reason_d;
    logic                  cond_ok;
    logic                  is_hint;

    assign cond_ok = emd_pkg::cond_pass(s1_cond_q, s1_flags_q);
    assign is_hint = ((s1_insn_q & emd_pkg::HINT_MASK) == emd_pkg::HINT_VAL);

    always_comb
    begin
        outcome_d = emd_pkg::EMD_EXEC;
        reason_d  = emd_pkg::EMD_WHY_NONE;
        if (!any_match)
        begin
            if (is_hint)
            begin
                outcome_d = emd_pkg::EMD_NOP;
                reason_d  = emd_pkg::EMD_WHY_HINT;
            end
            else
            begin
                outcome_d = emd_pkg::EMD_UNDEF;
                reason_d  = emd_pkg::EMD_WHY_NO_MATCH;
            end
        end
        else if (dec.cond_req && !cond_ok)
        begin
            // Condition fails before any pattern's own checks run
            outcome_d = emd_pkg::EMD_NOP;
            reason_d  = emd_pkg::EMD_WHY_COND_FAIL;
        end
        else if (cand_cnt != 3'h1)
        begin
            // A table with no single survivor is treated as unpredictable
            outcome_d = emd_pkg::EMD_UNPRED;
            reason_d  = emd_pkg::EMD_WHY_AMBIGUOUS;
        end
        else if (dec.special[sel])
        begin
            outcome_d = emd_pkg::EMD_UNPRED;
            reason_d  = emd_pkg::EMD_WHY_SPECIAL;
        end
        else if (!dec.sb_ok[sel])
        begin
            outcome_d = emd_pkg::EMD_UNPRED;
            reason_d  = emd_pkg::EMD_WHY_SHOULD_BE;
        end
    end

    // ------------------------------------------------------------
    // Result stage
    // ------------------------------------------------------------
    // A flush also stops the data outputs, so they keep the last result
    logic res_take;

    assign res_take = s1_valid_q && !in_flush;

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            out_valid <= 1'b0;
        end
        else if (clk_en)
        begin
            out_valid <= s1_valid_q && !in_flush;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            out_outcome <= emd_pkg::EMD_NOP;
        end
        else if (clk_en && res_take)
        begin
            out_outcome <= outcome_d;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            out_reason <= emd_pkg::EMD_WHY_NONE;
        end
        else if (clk_en && res_take)
        begin
            out_reason <= reason_d;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            out_match_cnt <= emd_pkg::CNT_RST;
        end
        else if (clk_en && res_take)
        begin
            out_match_cnt <= match_cnt;
        end
    end

    // ------------------------------------------------------------
    // Selected pattern and its fields
    // ------------------------------------------------------------

    // Fields pass only for a surviving executable pattern, so the
    // execute stage never sees half-decoded values
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            out_pat_id  <= emd_pkg::PID_RST;
            out_field_a <= emd_pkg::FLD_RST;
            out_field_b <= emd_pkg::FLD_RST;
        end
        else if (clk_en && res_take)
        begin
            if (outcome_d == emd_pkg::EMD_EXEC)
            begin
                out_pat_id  <= sel;
                out_field_a <= dec.field_a;
                out_field_b <= dec.field_b;
            end
            else
            begin
                out_pat_id  <= emd_pkg::PID_RST;
                out_field_a <= emd_pkg::FLD_RST;
                out_field_b <= emd_pkg::FLD_RST;
            end
        end
    end

    // Raw word follows the result for tracing and fault reporting
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            out_insn_valid <= 1'b0;
        end
        else if (clk_en)
        begin
            out_insn_valid <= s1_valid_q && !in_flush;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            out_insn <= emd_pkg::INSN_RST;
        end
        else if (clk_en && res_take)
        begin
            out_insn <= s1_insn_q;
        end
    end

endmodule : emd_decoder

`default_nettype wire

/* tb/emd_decoder_asserts.sv */
/*
 * Concurrent checks on the encoding match decoder ports.
 * Assumes one clock, core_clk, and async active-high sys_rst.
 */
`timescale 1ns/100ps
`default_nettype none

module emd_decoder_asserts (
    input wire logic                        core_clk,
    input wire logic                        sys_rst,
    input wire logic                        clk_en,
    input wire logic                        in_valid,
    input wire logic                        in_flush,
    input wire logic [emd_pkg::INSN_W-1:0]  in_insn,
    input wire logic [3:0]                  in_cond,
    input wire logic [3:0]                  in_flags,
    input wire logic                        out_valid,
    input wire emd_pkg::emd_outcome_t       out_outcome,
    input wire emd_pkg::emd_reason_t        out_reason,
    input wire logic [emd_pkg::PID_W-1:0]   out_pat_id,
    input wire logic [emd_pkg::FLD_W-1:0]   out_field_a,
    input wire logic [emd_pkg::FLD_W-1:0]   out_field_b,
    input wire logic [emd_pkg::CNT_W-1:0]   out_match_cnt,
    input wire logic                        out_insn_valid,
    input wire logic [emd_pkg::INSN_W-1:0]  out_insn
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_take;
        clk_en && in_valid && !in_flush;
    endsequence
    sequence s_move;
        clk_en && !in_flush;
    endsequence

    property p_lat;
        s_take ##1 s_move |=> out_valid && out_insn_valid && out_insn == $past(in_insn, 2);
    endproperty
    property p_hold;
        !clk_en |=> $stable(out_valid) && $stable(out_insn) && $stable(out_outcome);
    endproperty
    property p_flush;
        clk_en && in_flush |=> !out_valid;
    endproperty
    property p_cond;
        s_take ##0 (in_cond == 4'h0 && !in_flags[2]) ##1 s_move
            |=> out_valid && out_outcome != emd_pkg::EMD_EXEC;
    endproperty
    property p_fixed;
        out_valid && out_outcome == emd_pkg::EMD_EXEC |-> out_match_cnt != 3'h0
            && (out_insn & emd_pkg::PAT_TABLE[out_pat_id].fix_mask)
               == emd_pkg::PAT_TABLE[out_pat_id].fix_val;
    endproperty
    property p_nomatch;
        out_valid && out_match_cnt == 3'h0 |-> out_outcome == emd_pkg::EMD_UNDEF
            || out_outcome == emd_pkg::EMD_NOP;
    endproperty
    property p_hint;
        out_valid && out_match_cnt == 3'h0 && (out_insn & emd_pkg::HINT_MASK) == emd_pkg::HINT_VAL
            |-> out_outcome == emd_pkg::EMD_NOP && out_reason == emd_pkg::EMD_WHY_HINT;
    endproperty
    property p_quiet;
        out_valid && out_outcome != emd_pkg::EMD_EXEC
            |-> out_pat_id == 2'h0 && out_field_a == 8'h00 && out_field_b == 8'h00;
    endproperty
    property p_f0;
        out_valid && out_outcome == emd_pkg::EMD_EXEC && out_pat_id == 2'h0
            |-> out_field_a == {5'h00, out_insn[10:8]} && out_field_b == out_insn[7:0];
    endproperty
    property p_p3;
        out_valid && out_outcome == emd_pkg::EMD_EXEC && out_pat_id == 2'h3
            |-> !out_insn[7] && out_insn[2:0] == out_insn[5:3];
    endproperty

    a_lat: assert property (p_lat) else $error("result missing after two cycles");
    a_hold: assert property (p_hold) else $error("outputs moved while stalled");
    a_flush: assert property (p_flush) else $error("flushed word came out");
    a_cond: assert property (p_cond) else $error("failed condition executed");
    a_fixed: assert property (p_fixed) else $error("exec with fixed bits off");
    a_nomatch: assert property (p_nomatch) else $error("no match not fallback");
    a_hint: assert property (p_hint) else $error("hint not a no-op");
    a_quiet: assert property (p_quiet) else $error("fields on non-exec");
    a_f0: assert property (p_f0) else $error("fields not from word");
    a_p3: assert property (p_p3) else $error("bad word executed");
endmodule : emd_decoder_asserts

bind emd_decoder emd_decoder_asserts chk_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .in_valid(in_valid),
    .in_flush(in_flush), .in_insn(in_insn), .in_cond(in_cond), .in_flags(in_flags),
    .out_valid(out_valid), .out_outcome(out_outcome), .out_reason(out_reason),
    .out_pat_id(out_pat_id), .out_field_a(out_field_a), .out_field_b(out_field_b),
    .out_match_cnt(out_match_cnt), .out_insn_valid(out_insn_valid), .out_insn(out_insn)
);

`default_nettype wire

/* tb/emd_fetch_model.sv */
/*
 * Fetch stage model feeding the decoder one or two words back to back.
 * Assumes the bench keeps clk_en high while a word is offered.
 */
`timescale 1ns/100ps
`default_nettype none

module emd_fetch_model (
    input  wire logic                        core_clk,
    output var  logic                        in_valid,
    output var  logic [emd_pkg::INSN_W-1:0]  in_insn,
    output var  logic [3:0]                  in_cond,
    output var  logic [3:0]                  in_flags
);
    initial
    begin
        in_valid = 1'b0;
        in_insn = 16'hffff;
        in_cond = 4'he;
        in_flags = 4'h0;
    end

    task automatic send(input logic [15:0] w0, input logic [15:0] w1,
                        input logic [3:0] c, input logic [3:0] f, input bit two);
        @(posedge core_clk);
        #1;
        in_valid = 1'b1;
        in_insn = w0;
        in_cond = c;
        in_flags = f;
        if (two)
        begin
            @(posedge core_clk);
            #1;
            in_insn = w1;
        end
        @(posedge core_clk);
        #1;
        in_valid = 1'b0;
        // Idle word inverted so a stale value never looks valid
        in_insn = ~in_insn;
    endtask : send
endmodule : emd_fetch_model

`default_nettype wire

/* tb/emd_decoder_test.sv */
/*
 * Self-checking bench for the encoding match decoder.
 * Assumes the pattern table and condition encoding of the package.
 */
`timescale 1ns/100ps
`default_nettype none

module emd_decoder_test;
    logic core_clk, sys_rst, clk_en, in_flush, in_valid, out_valid, out_insn_valid;
    logic [15:0] in_insn, out_insn;
    logic [3:0] in_cond, in_flags;
    emd_pkg::emd_outcome_t out_outcome;
    emd_pkg::emd_reason_t out_reason;
    logic [1:0] out_pat_id;
    logic [7:0] out_field_a, out_field_b;
    logic [2:0] out_match_cnt;
    int n_mismatch = 0;
    int compares = 0;

    emd_fetch_model fm_u (.core_clk(core_clk), .in_valid(in_valid), .in_insn(in_insn),
                          .in_cond(in_cond), .in_flags(in_flags));
    emd_decoder dut_u (
        .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .in_valid(in_valid),
        .in_flush(in_flush), .in_insn(in_insn), .in_cond(in_cond), .in_flags(in_flags),
        .out_valid(out_valid), .out_outcome(out_outcome), .out_reason(out_reason),
        .out_pat_id(out_pat_id), .out_field_a(out_field_a), .out_field_b(out_field_b),
        .out_match_cnt(out_match_cnt), .out_insn_valid(out_insn_valid), .out_insn(out_insn)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic finish_test;
        if (n_mismatch == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test

    task automatic expect_out(input logic [1:0] oc, input logic [2:0] rs, input logic [1:0] pid,
                              input logic [7:0] fa, input logic [7:0] fb,
                              input logic [2:0] cnt, input logic [15:0] w);
        int i;
        i = 0;
        while (out_valid !== 1'b1 && i < 6)
        begin
            @(posedge core_clk);
            #1;
            i++;
        end
        chk(16'(out_valid), 16'h0001);
        chk(16'(out_insn_valid), 16'h0001);
        chk(out_insn, w);
        chk(16'(out_outcome), 16'(oc));
        chk(16'(out_reason), 16'(rs));
        chk(16'(out_pat_id), 16'(pid));
        chk({out_field_a, out_field_b}, {fa, fb});
        chk(16'(out_match_cnt), 16'(cnt));
    endtask : expect_out

    task automatic run1(input logic [15:0] w, input logic [3:0] c, input logic [3:0] f,
                        input logic [1:0] oc, input logic [2:0] rs, input logic [1:0] pid,
                        input logic [7:0] fa, input logic [7:0] fb, input logic [2:0] cnt);
        fm_u.send(w, 16'h0000, c, f, 1'b0);
        expect_out(oc, rs, pid, fa, fb, cnt, w);
    endtask : run1

    task automatic t_match;
        run1(16'h2345, 4'he, 4'h0, 2'h0, 3'h0, 2'h0, 8'h03, 8'h45, 3'h1);
        run1(16'h2845, 4'he, 4'h0, 2'h2, 3'h1, 2'h0, 8'h00, 8'h00, 3'h0);
        run1(16'hbf10, 4'he, 4'h0, 2'h1, 3'h2, 2'h0, 8'h00, 8'h00, 3'h0);
    endtask : t_match

    // Flags all clear: pass pattern over the sixteen codes
    task automatic t_cond;
        logic [15:0] pass;
        pass = 16'hd6aa;
        for (int c = 0; c < 16; c++)
        begin
            if (pass[c])
                run1(16'h2345, 4'(c), 4'h0, 2'h0, 3'h0, 2'h0, 8'h03, 8'h45, 3'h1);
            else
                run1(16'h2345, 4'(c), 4'h0, 2'h1, 3'h3, 2'h0, 8'h00, 8'h00, 3'h1);
        end
        run1(16'h2345, 4'h0, 4'h4, 2'h0, 3'h0, 2'h0, 8'h03, 8'h45, 3'h1);
        run1(16'h2345, 4'hc, 4'h8, 2'h1, 3'h3, 2'h0, 8'h00, 8'h00, 3'h1);
    endtask : t_cond

    task automatic t_yield;
        run1(16'h0005, 4'he, 4'h0, 2'h0, 3'h0, 2'h2, 8'h05, 8'h00, 3'h2);
        run1(16'h0045, 4'he, 4'h0, 2'h0, 3'h0, 2'h1, 8'h05, 8'h00, 3'h1);
        run1(16'h0005, 4'h0, 4'h0, 2'h1, 3'h3, 2'h0, 8'h00, 8'h00, 3'h2);
    endtask : t_yield

    task automatic t_special;
        run1(16'h4412, 4'he, 4'h0, 2'h0, 3'h0, 2'h3, 8'h02, 8'h02, 3'h1);
        run1(16'h4413, 4'he, 4'h0, 2'h3, 3'h5, 2'h0, 8'h00, 8'h00, 3'h1);
        run1(16'h4492, 4'he, 4'h0, 2'h3, 3'h6, 2'h0, 8'h00, 8'h00, 3'h1);
        run1(16'h4493, 4'he, 4'h0, 2'h3, 3'h5, 2'h0, 8'h00, 8'h00, 3'h1);
    endtask : t_special

    task automatic t_pair;
        fm_u.send(16'h2345, 16'h4413, 4'he, 4'h0, 1'b1);
        expect_out(2'h0, 3'h0, 2'h0, 8'h03, 8'h45, 3'h1, 16'h2345);
        @(posedge core_clk);
        #1;
        expect_out(2'h3, 3'h5, 2'h0, 8'h00, 8'h00, 3'h1, 16'h4413);
    endtask : t_pair

    task automatic t_flush_stall;
        fm_u.send(16'h2345, 16'h0000, 4'he, 4'h0, 1'b0);
        in_flush = 1'b1;
        @(posedge core_clk);
        #1;
        in_flush = 1'b0;
        repeat (3)
        begin
            @(posedge core_clk);
            #1;
            chk(16'(out_valid), 16'h0000);
        end
        fm_u.send(16'h4412, 16'h0000, 4'he, 4'h0, 1'b0);
        clk_en = 1'b0;
        repeat (3)
        begin
            @(posedge core_clk);
            #1;
            chk(16'(out_valid), 16'h0000);
        end
        clk_en = 1'b1;
        expect_out(2'h0, 3'h0, 2'h3, 8'h02, 8'h02, 3'h1, 16'h4412);
    endtask : t_flush_stall

    initial
    begin
        sys_rst = 1'b1;
        clk_en = 1'b1;
        in_flush = 1'b0;
        repeat (12) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        chk(16'(out_outcome), 16'h0001);
        t_match();
        t_cond();
        t_yield();
        t_special();
        t_pair();
        t_flush_stall();
        finish_test();
    end

    // Whole run is just over a hundred cycles
    initial
    begin
        #100000;
        n_mismatch++;
        finish_test();
    end
endmodule : emd_decoder_test

`default_nettype wire
